// File: common/pmm_pkg.sv
/*
 * pmm_pkg: shared constants and types for the management bit-behaviour bank.
 * Assumes a 50 MHz management clock and a 32-bit APB register bus.
 */
package pmm_pkg;

	// ****************************************
	// register map and widths
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_OP = 2;
	localparam int NUM_TONE = 6;
	localparam int NUM_CNT = 5;
	localparam int CNT_W = 16;
	localparam int MEAS_W = 16;
	localparam int IVL_W = 8;
	localparam int PAR_W = 7;
	localparam int CIDX_W = 3;
	localparam int CIDX_LSB = 2;

	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_INTERVAL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_MARGIN = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_MEASURE = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_SKEW = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_CNT0 = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_CNT_END = 8'h30;
	localparam logic [1:0] WORD_ALIGN = 2'h0;

	// control register fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_TONE_LSB = 2;
	localparam int CTRL_FEC_EN = 8;
	localparam int CTRL_PHY_RST = 9;

	// status register fields
	localparam int ST_LINK = 0;
	localparam int ST_T10 = 1;
	localparam int ST_TXF = 2;
	localparam int ST_RXF = 3;

	// margin register field positions
	localparam int MA_LSB = 0;
	localparam int MB_LSB = 8;
	localparam int TH_LSB = 16;
	localparam int MODE_LSB = 24;

	// counters 2..4 are the error-correction counters
	localparam logic [NUM_CNT-1:0] FEC_CNT_MASK = 5'h1c;

	// ****************************************
	// field values
	// ****************************************
	localparam logic [IVL_W-1:0] IVL_10 = 8'h0a;
	localparam logic [IVL_W-1:0] IVL_20 = 8'h14;
	localparam logic [IVL_W-1:0] IVL_40 = 8'h28;
	localparam logic [IVL_W-1:0] IVL_RST = IVL_20;
	localparam logic [PAR_W-1:0] MARGIN_MIN = 7'h03;
	localparam logic [PAR_W-1:0] MARGIN_MAX = 7'h59;
	localparam logic [PAR_W-1:0] THIRD_MIN = 7'h01;
	localparam logic [PAR_W-1:0] THIRD_MAX = 7'h56;
	localparam logic [1:0] MODE_BAD = 2'h3;
	localparam logic [1:0] MODE_RST = 2'h0;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int OP_TIMEOUT_S = 10;
	localparam int SKEW_PERIOD_S = 1;
	localparam int OP_TIMEOUT_CYC = OP_TIMEOUT_S * CLK_HZ;
	localparam int SKEW_PERIOD_CYC = SKEW_PERIOD_S * CLK_HZ;
	localparam int TMR_W = 30;

	typedef enum logic [1:0] {
		OP_IDLE = 2'b01,
		OP_RUN = 2'b10
	} pmm_op_state_t;

	typedef struct packed {
		logic [1:0] mode;
		logic [PAR_W-1:0] third;
		logic [PAR_W-1:0] margin_b;
		logic [PAR_W-1:0] margin_a;
	} pmm_margin_t;

endpackage : pmm_pkg

// File: testbench/pmm_mgmt_bank_tb.sv
/* pmm_mgmt_bank_tb: self-checking bench for the management bank over APB.
   Assumes one wait state per transfer and shortened timer parameters. */
`timescale 1ns/1ps
`default_nettype none
module pmm_mgmt_bank_tb import pmm_pkg::*; ;
	localparam int TMO = 50;
	localparam int SKW = 20;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} pmm_exp_t;
	logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata;
	logic pready, pslverr, link_up_pin = 1'b0, link_fail = 1'b0, t10 = 1'b0;
	logic tx_f = 1'b0, rx_f = 1'b0, meas_valid = 1'b0, ok = 1'b1, hang = 1'b0;
	logic [7:0] lat = 8'h1e, ivl_exp = IVL_RST;
	logic [7:0] ivl_try[7] = '{8'h28, 8'h00, 8'h0a, 8'h0b, 8'h14, 8'h29, 8'hff};
	logic [31:0] mar_try[3] = '{32'h0357_5902, 32'h0156_5a59, 32'h0200_0303};
	logic [MEAS_W-1:0] meas_val = '0, skew_meas = '0;
	logic [NUM_CNT-1:0] cnt_evt = '0;
	logic [NUM_OP-1:0] op_done, op_ok, op_start, op_abort;
	logic [NUM_TONE-1:0] tone_done, tone_start;
	logic [IVL_W-1:0] interval;
	logic fec_o, prst_o;
	logic [31:0] seed = 32'h2548fc6c, mx = 32'h0001_0303, w;
	pmm_margin_t margin;
	pmm_exp_t expq[$];
	pmm_exp_t mon_e;
	int fail_count = 0, checked = 0;

	initial begin
		forever #10 mclk = ~mclk;
	end

	pmm_mgmt_bank #(.OP_TMO_CYC(TMO), .SKEW_CYC(SKW)) dut (.mclk(mclk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link_up_pin(link_up_pin),
		.link_fail(link_fail), .t10_status_in(t10), .op_done(op_done), .op_ok(op_ok),
		.op_start(op_start), .op_abort(op_abort), .tone_done(tone_done),
		.tone_start(tone_start), .tx_fault_det(tx_f), .rx_fault_det(rx_f),
		.meas_valid(meas_valid), .meas_val(meas_val), .skew_meas(skew_meas),
		.cnt_evt(cnt_evt), .fec_enable(fec_o), .phy_reset_pulse(prst_o), .interval(interval),
		.margin(margin));
	pmm_phy_model phy (.mclk(mclk), .sys_rst(sys_rst), .op_start(op_start),
		.op_abort(op_abort), .tone_start(tone_start), .ok(ok), .hang(hang), .lat(lat),
		.op_done(op_done), .op_ok(op_ok), .tone_done(tone_done));

	// ****
	// helpers
	// ****
	function automatic logic [31:0] pmm_lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : pmm_lfsr

	// each field is judged on its own, bad fields keep their old value
	function automatic logic [31:0] mar_upd(input logic [31:0] o, input logic [31:0] v);
		logic [31:0] n;
		n = o;
		if (v[6:0] >= 7'h03 && v[6:0] <= 7'h59) n[6:0] = v[6:0];
		if (v[14:8] >= 7'h03 && v[14:8] <= 7'h59) n[14:8] = v[14:8];
		if (v[22:16] >= 7'h01 && v[22:16] <= 7'h56) n[22:16] = v[22:16];
		if (v[25:24] != 2'h3) n[25:24] = v[25:24];
		return n;
	endfunction : mar_upd

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (exp !== got) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	task automatic xfer(input logic is_wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= is_wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		// no own limit: only the watchdog ends a wait for the answer
		while (pready !== 1'b1) begin
			@(posedge mclk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [31:0] m);
		expq.push_back('{d: d & m, m: m, e: (a >= OFF_CNT_END)});
		xfer(1'b0, a, 32'h0);
	endtask : rd

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		expq.push_back('{d: 32'h0, m: 32'h0, e: (a >= OFF_CNT_END)});
		xfer(1'b1, a, d);
	endtask : wr

	task automatic give_verdict();
		if (expq.size() != 0) fail_count++;
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	// ****
	// answer monitor
	// ****
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1) begin
			if (expq.size() == 0) begin
				cmp("unexpected answer", 32'h0, 32'h1);
			end else begin
				mon_e = expq.pop_front();
				cmp("prdata", mon_e.d, prdata & mon_e.m);
				cmp("pslverr", {31'h0, mon_e.e}, {31'h0, pslverr});
			end
		end
	end

	initial begin
		repeat (90000) @(posedge mclk);
		fail_count++;
		give_verdict();
	end

	// ****
	// scenarios
	// ****
	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(OFF_INTERVAL, {24'h0, IVL_RST}, 32'hff);
		rd(OFF_MARGIN, mx, 32'h037f7f7f);
		rd(OFF_RESULT, 32'h0, 32'h3);
		rd(OFF_MEASURE, 32'hffff, 32'hffff);
		rd(OFF_CNT0, 32'h0, 32'hffff);
		rd(8'h40, 32'h0, 32'hffffffff);
		wr(8'h40, 32'h5);
		$display("test reset finished");
		foreach (ivl_try[i]) begin
			wr(OFF_INTERVAL, {24'h0, ivl_try[i]});
			if (ivl_try[i] inside {IVL_10, IVL_20, IVL_40}) ivl_exp = ivl_try[i];
			rd(OFF_INTERVAL, {24'h0, ivl_exp}, 32'hff);
			cmp("interval", {24'h0, ivl_exp}, {24'h0, interval});
		end
		for (int i = 0; i < 11; i++) begin
			seed = pmm_lfsr(seed);
			w = (i < 3) ? mar_try[i] : (seed & 32'h037f7f7f);
			mx = mar_upd(mx, w);
			wr(OFF_MARGIN, w);
			rd(OFF_MARGIN, mx, 32'h037f7f7f);
			cmp("margin", {9'h0, mx[25:24], mx[22:16], mx[14:8], mx[6:0]}, {9'h0, margin});
		end
		$display("test fields finished");
		link_up_pin <= 1'b1;
		cyc(8);
		wr(OFF_CTRL, 32'h3);
		rd(OFF_CTRL, 32'h3, 32'h3);
		cyc(40);
		rd(OFF_CTRL, 32'h0, 32'h3);
		hang <= 1'b1;
		wr(OFF_CTRL, 32'h2);
		rd(OFF_CTRL, 32'h2, 32'h3);
		cyc(TMO + 10);
		rd(OFF_CTRL, 32'h0, 32'h3);
		rd(OFF_RESULT, 32'h1, 32'h3);
		rd(OFF_RESULT, 32'h0, 32'h3);
		hang <= 1'b0;
		wr(OFF_CTRL, 32'h1);
		cyc(40);
		link_up_pin <= 1'b0;
		cyc(8);
		wr(OFF_CTRL, 32'h1);
		rd(OFF_CTRL, 32'h0, 32'h3);
		rd(OFF_RESULT, 32'h0, 32'h3);
		link_up_pin <= 1'b1;
		wr(OFF_CTRL, 32'hfc);
		rd(OFF_CTRL, 32'hfc, 32'hfc);
		cyc(40);
		rd(OFF_CTRL, 32'h0, 32'hfc);
		$display("test commands finished");
		cnt_evt <= '1;
		cyc(7);
		cnt_evt <= '0;
		for (int i = 0; i < NUM_CNT; i++) begin
			rd(OFF_CNT0 + 8'(4 * i), 32'h7, 32'hffff);
			rd(OFF_CNT0 + 8'(4 * i), 32'h0, 32'hffff);
		end
		cnt_evt <= '1;
		cyc(65540);
		cnt_evt <= '0;
		for (int i = 0; i < NUM_CNT; i++) rd(OFF_CNT0 + 8'(4 * i), 32'hffff, 32'hffff);
		cnt_evt <= '1;
		cyc(5);
		cnt_evt <= '0;
		wr(OFF_CTRL, 32'h100);
		rd(OFF_CTRL, 32'h100, 32'h300);
		cmp("fec_enable", 32'h1, {31'h0, fec_o});
		wr(OFF_CTRL, 32'h300);
		@(posedge mclk);
		cmp("phy_reset_pulse", 32'h1, {31'h0, prst_o});
		rd(OFF_CTRL, 32'h0, 32'h300);
		cmp("fec_enable", 32'h0, {31'h0, fec_o});
		cmp("phy_reset_pulse", 32'h0, {31'h0, prst_o});
		for (int i = 0; i < NUM_CNT; i++) begin
			rd(OFF_CNT0 + 8'(4 * i), FEC_CNT_MASK[i] ? 32'h0 : 32'h5, 32'hffff);
		end
		$display("test counters finished");
		t10 <= 1'b1;
		tx_f <= 1'b1;
		rx_f <= 1'b1;
		@(posedge mclk);
		tx_f <= 1'b0;
		rd(OFF_STATUS, 32'hf, 32'hf);
		rd(OFF_STATUS, 32'hb, 32'hf);
		link_fail <= 1'b1;
		rx_f <= 1'b0;
		rd(OFF_STATUS, 32'h9, 32'hf);
		rd(OFF_STATUS, 32'h1, 32'hf);
		link_fail <= 1'b0;
		meas_valid <= 1'b1;
		seed = pmm_lfsr(seed);
		meas_val <= seed[15:0];
		skew_meas <= seed[31:16];
		cyc(SKW + 5);
		rd(OFF_MEASURE, {16'h0, seed[15:0]}, 32'hffff);
		rd(OFF_SKEW, {16'h0, seed[31:16]}, 32'hffff);
		meas_valid <= 1'b0;
		cyc(2);
		rd(OFF_MEASURE, 32'hffff, 32'hffff);
		$display("test status finished");
		@(posedge mclk);
		give_verdict();
	end
endmodule : pmm_mgmt_bank_tb
`default_nettype wire

// File: testbench/pmm_phy_model.sv
/* pmm_phy_model: far-side model that answers operation and tone commands.
   Assumes registered one-cycle start and abort pulses from the bank on mclk. */
`timescale 1ns/1ps
`default_nettype none
module pmm_phy_model import pmm_pkg::*; (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [NUM_OP-1:0] op_start,
	input wire logic [NUM_OP-1:0] op_abort,
	input wire logic [NUM_TONE-1:0] tone_start,
	input wire logic ok,
	input wire logic hang,
	input wire logic [7:0] lat,
	output logic [NUM_OP-1:0] op_done,
	output logic [NUM_OP-1:0] op_ok,
	output logic [NUM_TONE-1:0] tone_done
);
	// ****
	// command tracking
	// ****
	logic [NUM_OP-1:0] op_pend;
	logic [NUM_TONE-1:0] tone_pend;
	logic [7:0] wait_cnt;
	// outcome only counts with done, so it shows the opposite in between
	always_ff @(posedge mclk) begin
		op_done <= '0;
		tone_done <= '0;
		op_ok <= {NUM_OP{~ok}};
		if (sys_rst) begin
			op_pend <= '0;
			tone_pend <= '0;
			wait_cnt <= '0;
		end else if (|op_start || |tone_start) begin
			op_pend <= op_pend | op_start;
			tone_pend <= tone_pend | tone_start;
			wait_cnt <= lat;
		end else if (wait_cnt != 8'h00) begin
			wait_cnt <= wait_cnt - 8'h01;
			op_pend <= op_pend & ~op_abort;
		end else if (!hang) begin
			op_done <= op_pend & ~op_abort;
			op_ok <= {NUM_OP{ok}} & op_pend;
			tone_done <= tone_pend;
			op_pend <= '0;
			tone_pend <= '0;
		end else begin
			op_pend <= op_pend & ~op_abort;
		end
	end
endmodule : pmm_phy_model
`default_nettype wire

// File: verilog/pmm_mgmt_bank.sv
/*
 * pmm_mgmt_bank: management register bank with operation, tone-command,
 * range-checked, latching and clear-on-read behaviour, reached over APB.
 * Assumes PHY-side status and event inputs are synchronous to mclk,
 * except link_up_pin which arrives from a pin.
 */
`timescale 1ns/1ps
`default_nettype none

module pmm_mgmt_bank import pmm_pkg::*; #(
	parameter int OP_TMO_CYC = OP_TIMEOUT_CYC,
	parameter int SKEW_CYC = SKEW_PERIOD_CYC,
	parameter bit TX_FAULT_CAP = 1'b1,
	parameter bit RX_FAULT_CAP = 1'b1
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic link_up_pin,
	input wire logic link_fail,
	input wire logic t10_status_in,
	input wire logic [NUM_OP-1:0] op_done,
	input wire logic [NUM_OP-1:0] op_ok,
	output logic [NUM_OP-1:0] op_start,
	output logic [NUM_OP-1:0] op_abort,
	input wire logic [NUM_TONE-1:0] tone_done,
	output logic [NUM_TONE-1:0] tone_start,
	input wire logic tx_fault_det,
	input wire logic rx_fault_det,
	input wire logic meas_valid,
	input wire logic [MEAS_W-1:0] meas_val,
	input wire logic [MEAS_W-1:0] skew_meas,
	input wire logic [NUM_CNT-1:0] cnt_evt,
	output logic fec_enable,
	output logic phy_reset_pulse,
	output logic [IVL_W-1:0] interval,
	output pmm_margin_t margin
);

	localparam logic [TMR_W-1:0] TMO_LAST = TMR_W'(OP_TMO_CYC - 1);
	localparam logic [TMR_W-1:0] SKEW_LAST = TMR_W'(SKEW_CYC - 1);

	// ****************************************
	// link pin synchroniser
	// ****************************************
	logic lk_s1, lk_s2, lk_s3, link_up;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lk_s1 <= 1'b0;
			lk_s2 <= 1'b0;
			lk_s3 <= 1'b0;
		end else begin
			lk_s1 <= link_up_pin;
			lk_s2 <= lk_s1;
			lk_s3 <= lk_s2;
		end
	end

	// a glitch must survive two stages before the link state moves
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			link_up <= 1'b0;
		end else if (lk_s2 == lk_s3) begin
			link_up <= lk_s3;
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	logic acc, rd_now, wr_now, hit;
	logic [DATA_W-1:0] rdata;
	logic sel_ctrl, sel_res, sel_ivl, sel_mar, sel_st;
	logic wr_ctrl, wr_ivl, wr_mar, rd_res, rd_st, phy_rst_req;
	logic [NUM_CNT-1:0] cnt_rd;
	logic [ADDR_W-1:0] cnt_off;
	logic [CIDX_W-1:0] cnt_idx;

	// one wait state; read side effects happen as the data is captured
	assign acc = psel & penable;
	assign rd_now = acc & ~pwrite & ~pready;
	assign wr_now = acc & pwrite & pready;
	assign cnt_off = paddr - OFF_CNT0;
	assign cnt_idx = cnt_off[CIDX_LSB +: CIDX_W];

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= acc & ~pready;
			pslverr <= acc & ~pready & ~hit;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			prdata <= '0;
		end else if (rd_now) begin
			prdata <= rdata;
		end
	end

	// ****************************************
	// state declarations
	// ****************************************
	pmm_op_state_t op_st [NUM_OP];
	logic [TMR_W-1:0] op_tmr [NUM_OP];
	logic [NUM_OP-1:0] op_req, op_res, op_go, op_concl;
	logic [NUM_TONE-1:0] tone_busy, tone_go;
	logic t10_status, tx_lat, rx_lat;
	logic [MEAS_W-1:0] meas_reg, skew_reg;
	logic [TMR_W-1:0] skew_div;
	logic [CNT_W-1:0] cnt_val [NUM_CNT];

	// ****************************************
	// address decode and read mux
	// ****************************************
	always_comb begin
		sel_ctrl = 1'b0;
		sel_res = 1'b0;
		sel_ivl = 1'b0;
		sel_mar = 1'b0;
		sel_st = 1'b0;
		hit = 1'b1;
		rdata = '0;
		cnt_rd = '0;
		if (paddr == OFF_CTRL) begin
			sel_ctrl = 1'b1;
			rdata[CTRL_OP_LSB +: NUM_OP] = op_req;
			rdata[CTRL_TONE_LSB +: NUM_TONE] = tone_busy;
			rdata[CTRL_FEC_EN] = fec_enable;
		end else if (paddr == OFF_RESULT) begin
			sel_res = 1'b1;
			rdata[NUM_OP-1:0] = op_res;
		end else if (paddr == OFF_INTERVAL) begin
			sel_ivl = 1'b1;
			rdata[IVL_W-1:0] = interval;
		end else if (paddr == OFF_MARGIN) begin
			sel_mar = 1'b1;
			rdata[MA_LSB +: PAR_W] = margin.margin_a;
			rdata[MB_LSB +: PAR_W] = margin.margin_b;
			rdata[TH_LSB +: PAR_W] = margin.third;
			rdata[MODE_LSB +: 2] = margin.mode;
		end else if (paddr == OFF_STATUS) begin
			sel_st = 1'b1;
			rdata[ST_LINK] = link_up;
			rdata[ST_T10] = t10_status;
			rdata[ST_TXF] = tx_lat;
			rdata[ST_RXF] = rx_lat;
		end else if (paddr == OFF_MEASURE) begin
			rdata[MEAS_W-1:0] = meas_reg;
		end else if (paddr == OFF_SKEW) begin
			rdata[MEAS_W-1:0] = skew_reg;
		end else if (paddr >= OFF_CNT0 && paddr < OFF_CNT_END && paddr[1:0] == WORD_ALIGN) begin
			for (int i = 0; i < NUM_CNT; i++) begin
				if (cnt_idx == CIDX_W'(i)) begin
					rdata[CNT_W-1:0] = cnt_val[i];
					cnt_rd[i] = rd_now;
				end
			end
		end else begin
			hit = 1'b0;
		end
	end

	assign wr_ctrl = wr_now & sel_ctrl;
	assign wr_ivl = wr_now & sel_ivl;
	assign wr_mar = wr_now & sel_mar;
	assign rd_res = rd_now & sel_res;
	assign rd_st = rd_now & sel_st;
	assign phy_rst_req = wr_ctrl & pwdata[CTRL_PHY_RST];

	// ****************************************
	// link parameter operations
	// ****************************************
	always_comb begin
		for (int i = 0; i < NUM_OP; i++) begin
			op_req[i] = op_st[i] == OP_RUN;
			op_go[i] = wr_ctrl & pwdata[CTRL_OP_LSB + i] & (op_st[i] == OP_IDLE);
			op_concl[i] = op_req[i] & (op_done[i] | op_tmr[i] == TMO_LAST);
		end
	end

	always_ff @(posedge mclk) begin
		for (int i = 0; i < NUM_OP; i++) begin
			if (sys_rst) begin
				op_st[i] <= OP_IDLE;
			end else begin
				case (op_st[i])
					OP_IDLE: begin
						// with the link down the request never starts
						if (op_go[i] && link_up) begin
							op_st[i] <= OP_RUN;
						end
					end
					OP_RUN: begin
						if (op_concl[i]) begin
							op_st[i] <= OP_IDLE;
						end
					end
					default: begin
						op_st[i] <= OP_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		for (int i = 0; i < NUM_OP; i++) begin
			if (sys_rst || op_st[i] != OP_RUN) begin
				op_tmr[i] <= '0;
			end else begin
				op_tmr[i] <= op_tmr[i] + TMR_W'(1);
			end
		end
	end

	// outcome wins over a read in the same cycle
	always_ff @(posedge mclk) begin
		for (int i = 0; i < NUM_OP; i++) begin
			if (sys_rst) begin
				op_res[i] <= 1'b0;
			end else if (op_concl[i]) begin
				op_res[i] <= op_done[i] & op_ok[i];
			end else if (op_go[i] && !link_up) begin
				op_res[i] <= 1'b0;
			end else if (rd_res) begin
				op_res[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			op_start <= '0;
			op_abort <= '0;
		end else begin
			op_start <= op_go & {NUM_OP{link_up}};
			op_abort <= op_concl & ~op_done;
		end
	end

	// ****************************************
	// tone commands
	// ****************************************
	assign tone_go = {NUM_TONE{wr_ctrl}} & pwdata[CTRL_TONE_LSB +: NUM_TONE] & ~tone_busy;

	// a command already running ignores a second request
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tone_busy <= '0;
			tone_start <= '0;
		end else begin
			tone_busy <= (tone_busy & ~tone_done) | tone_go;
			tone_start <= tone_go;
		end
	end

	// ****************************************
	// FEC enable and PHY reset
	// ****************************************
	always_ff @(posedge mclk) begin
		if (sys_rst || phy_rst_req) begin
			fec_enable <= 1'b0;
		end else if (wr_ctrl) begin
			fec_enable <= pwdata[CTRL_FEC_EN];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			phy_reset_pulse <= 1'b0;
		end else begin
			phy_reset_pulse <= phy_rst_req;
		end
	end

	// ****************************************
	// range-checked configuration
	// ****************************************
	logic [IVL_W-1:0] w_ivl;
	logic [PAR_W-1:0] w_ma, w_mb, w_th;
	logic [1:0] w_mode;

	assign w_ivl = pwdata[IVL_W-1:0];
	assign w_ma = pwdata[MA_LSB +: PAR_W];
	assign w_mb = pwdata[MB_LSB +: PAR_W];
	assign w_th = pwdata[TH_LSB +: PAR_W];
	assign w_mode = pwdata[MODE_LSB +: 2];

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			interval <= IVL_RST;
		end else if (wr_ivl && (w_ivl == IVL_10 || w_ivl == IVL_20 || w_ivl == IVL_40)) begin
			interval <= w_ivl;
		end
	end

	// each field is checked on its own; a bad field leaves only itself alone
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			margin <= '{mode: MODE_RST, third: THIRD_MIN, margin_b: MARGIN_MIN,
				margin_a: MARGIN_MIN};
		end else if (wr_mar) begin
			if (w_ma >= MARGIN_MIN && w_ma <= MARGIN_MAX) begin
				margin.margin_a <= w_ma;
			end
			if (w_mb >= MARGIN_MIN && w_mb <= MARGIN_MAX) begin
				margin.margin_b <= w_mb;
			end
			if (w_th >= THIRD_MIN && w_th <= THIRD_MAX) begin
				margin.third <= w_th;
			end
			if (w_mode != MODE_BAD) begin
				margin.mode <= w_mode;
			end
		end
	end

	// ****************************************
	// status, faults and measurements
	// ****************************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			t10_status <= 1'b0;
			tx_lat <= 1'b0;
			rx_lat <= 1'b0;
		end else begin
			t10_status <= t10_status_in & ~link_fail;
			// a read re-arms the latch to the present condition
			tx_lat <= TX_FAULT_CAP & (tx_fault_det | (tx_lat & ~rd_st));
			rx_lat <= RX_FAULT_CAP & (rx_fault_det | (rx_lat & ~rd_st));
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meas_reg <= '1;
		end else begin
			meas_reg <= (link_up && meas_valid) ? meas_val : '1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || skew_div == SKEW_LAST) begin
			skew_div <= '0;
		end else begin
			skew_div <= skew_div + TMR_W'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			skew_reg <= '0;
		end else if (skew_div == SKEW_LAST) begin
			skew_reg <= skew_meas;
		end
	end

	// ****************************************
	// clear-on-read counters
	// ****************************************
	for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
		pmm_sat_cnt #(.W(CNT_W)) u_cnt (
			.mclk(mclk),
			.sys_rst(sys_rst),
			.clr(cnt_rd[g] | (FEC_CNT_MASK[g] & phy_rst_req)),
			.inc(cnt_evt[g]),
			.cnt(cnt_val[g])
		);
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_op_timeout;
		op_req[1] && op_tmr[1] == TMO_LAST && !op_done[1];
	endsequence

	sequence s_op_result_zero;
		!op_req[0] && !op_res[0];
	endsequence

	op_hold_a: assert property (op_req[0] && !op_concl[0] |=> op_req[0])
		else $error("operation bit dropped while running");

	op_timeout_a: assert property (s_op_timeout |=> !op_req[1] && !op_res[1] && op_abort[1]
		##1 !op_abort[1])
		else $error("timeout did not end operation as failed");

	link_down_a: assert property (op_go[0] && !link_up |=> s_op_result_zero)
		else $error("request with link down not failed at once");

	result_load_a: assert property (op_req[0] && op_done[0] |=> op_res[0] == $past(op_ok[0]))
		else $error("result bit does not match outcome");

	result_clr_a: assert property (rd_res && !op_concl[1] |=> !op_res[1])
		else $error("result bit survived a read");

	tone_hold_a: assert property (tone_busy[0] && !tone_done[0] |=> tone_busy[0])
		else $error("tone command bit dropped early");

	tone_end_a: assert property (tone_busy[2] && tone_done[2] |=> !tone_busy[2])
		else $error("tone command bit not cleared on completion");

	ivl_check_a: assert property (wr_ivl && w_ivl != IVL_10 && w_ivl != IVL_20
		&& w_ivl != IVL_40 |=> $stable(interval))
		else $error("invalid interval accepted");

	margin_check_a: assert property (wr_mar && w_ma > MARGIN_MAX |=> $stable(margin.margin_a))
		else $error("out of range margin accepted");

	third_check_a: assert property (wr_mar && w_th < THIRD_MIN |=> $stable(margin.third))
		else $error("out of range third field accepted");

	mode_check_a: assert property (margin.mode != MODE_BAD)
		else $error("invalid mode code stored");

	meas_ones_a: assert property (!link_up |=> meas_reg == '1)
		else $error("measured value not all ones with link down");

	status_force_a: assert property (link_fail |=> !t10_status)
		else $error("status bit set during link failure");

	fault_latch_a: assert property (tx_fault_det ##1 !rd_st |=> tx_lat == TX_FAULT_CAP)
		else $error("transmit fault not latched");

	fec_clear_a: assert property (phy_rst_req |=> !fec_enable && phy_reset_pulse ##1 !phy_reset_pulse)
		else $error("FEC enable survived PHY reset");

endmodule : pmm_mgmt_bank

`default_nettype wire

// File: verilog/pmm_sat_cnt.sv
/*
 * pmm_sat_cnt: clear-on-read event counter that sticks at all ones.
 * Assumes clr and inc are single-cycle strobes on mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module pmm_sat_cnt import pmm_pkg::*; #(
	parameter int W = CNT_W
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clr,
	input wire logic inc,
	output logic [W-1:0] cnt
);

	// ****************************************
	// counter
	// ****************************************
	// an event in the clearing cycle counts as one, so nothing is lost
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt <= '0;
		end else if (clr) begin
			cnt <= inc ? W'(1) : '0;
		end else if (inc && !(&cnt)) begin
			cnt <= cnt + W'(1);
		end
	end

	sat_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
		(&cnt) && !clr |=> (&cnt))
		else $error("saturated counter moved without a clear");

	clr_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
		clr && !inc |=> cnt == '0)
		else $error("counter not zero after clear");

endmodule : pmm_sat_cnt

`default_nettype wire
